// [rtl/pll_serial_latch_loader.sv]
// Serial three-wire load port with addressed latches.
`timescale 1ns/1ps
`default_nettype none
module pll_serial_latch_loader
	import serial_loader_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic serial_clock_in,
	input wire logic serial_data_in,
	input wire logic latch_load_strobe_in,
	input wire logic power_up_control_in,
	input wire logic lock_detect_in,
	output logic [23:0] reference_latch_out,
	output logic [23:0] feedback_latch_out,
	output logic [23:0] function_latch_out,
	output logic output_active_out,
	output logic power_down_out,
	output logic multiplexed_status_output
);
	// ------------------------------------------------------------
	// Reset release and input synchronisers.
	// ------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync_q <= SYNC_RESET;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	logic sck_rise;
	logic strobe_rise;
	logic serial_data_in_level;
	logic pwr_level;
	logic lock_level;
	sync_edge u_sck (.clock_in(clock_in), .rst_n_in(rst_n), .async_in(serial_clock_in),
		.level_out(), .rise_out(sck_rise));
	sync_edge u_le (.clock_in(clock_in), .rst_n_in(rst_n), .async_in(latch_load_strobe_in),
		.level_out(), .rise_out(strobe_rise));
	sync_edge u_sd (.clock_in(clock_in), .rst_n_in(rst_n), .async_in(serial_data_in),
		.level_out(serial_data_in_level), .rise_out());
	sync_edge u_pw (.clock_in(clock_in), .rst_n_in(rst_n), .async_in(power_up_control_in),
		.level_out(pwr_level), .rise_out());
	sync_edge u_lk (.clock_in(clock_in), .rst_n_in(rst_n), .async_in(lock_detect_in),
		.level_out(lock_level), .rise_out());

	// ------------------------------------------------------------
	// Start-up guard for the edge detectors.
	// ------------------------------------------------------------
	// The synchronisers leave reset at zero while the idle strobe pin is high.
	// Edges count only once the guard has filled, so no false load follows reset.
	logic [2:0] settle_q, settle_d;
	logic settled;
	logic shift_pulse;
	logic load_pulse;

	always_comb begin
		settle_d = {settle_q[1:0], 1'b1};
	end

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			settle_q <= FLAG_RESET;
		end else begin
			settle_q <= settle_d;
		end
	end

	assign settled = settle_q[2];
	assign shift_pulse = sck_rise & settled;
	assign load_pulse = strobe_rise & settled;

	// ------------------------------------------------------------
	// Shift register and latches.
	// ------------------------------------------------------------
	logic [23:0] shift_q, shift_d;
	logic [23:0] ref_q, ref_d, fb_q, fb_d, func_q, func_d;
	logic [2:0] done_q, done_d;
	logic active_q, active_d, pd_q, pd_d, mux_q, mux_d;
	logic [3:0] load_enables;

	// ------------------------------------------------------------
	// Destination decode.
	// ------------------------------------------------------------
	// Turns the two select bits of a word into one of four enables, one per select code.
	function automatic logic [3:0] latch_enables(input logic [1:0] latch_select_bits);
		logic [3:0] enables;
		enables = 4'h0;
		if (latch_select_bits == SEL_REFERENCE) begin
			enables = 4'h1;
		end else if (latch_select_bits == SEL_FEEDBACK) begin
			enables = 4'h2;
		end else if (latch_select_bits == SEL_FUNCTION) begin
			enables = 4'h4;
		end else begin
			enables = 4'h8;
		end
		return enables;
	endfunction : latch_enables

	assign load_enables = latch_enables(shift_q[1:0]);

	// ------------------------------------------------------------
	// Next-state logic for the shift register and latches.
	// ------------------------------------------------------------

	always_comb begin
		shift_d = shift_q;
		ref_d = ref_q;
		fb_d = fb_q;
		func_d = func_q;
		done_d = done_q;
		if (shift_pulse) begin
			shift_d = {shift_q[22:0], serial_data_in_level};
		end
		if (load_pulse) begin
			if (load_enables[0]) begin
				ref_d = shift_q;
				done_d[0] = 1'b1;
			end
			if (load_enables[1]) begin
				fb_d = shift_q;
				done_d[1] = 1'b1;
			end
			if (load_enables[2] | load_enables[3]) begin
				func_d = shift_q;
			end
			if (load_enables[3]) begin
				done_d[2] = 1'b1;
			end
		end
		active_d = (done_q == INIT_DONE_ALL);
		pd_d = ~pwr_level | func_q[PD_BIT];
		mux_d = (func_q[STATUS_LSB +: 2] == STATUS_LOCK_MODE) ? lock_level : 1'b0;
	end

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= LATCH_RESET;
			ref_q <= LATCH_RESET;
			fb_q <= LATCH_RESET;
			func_q <= LATCH_RESET;
			done_q <= FLAG_RESET;
			active_q <= 1'b0;
			pd_q <= 1'b1;
			mux_q <= 1'b0;
		end else begin
			shift_q <= shift_d;
			ref_q <= ref_d;
			fb_q <= fb_d;
			func_q <= func_d;
			done_q <= done_d;
			active_q <= active_d;
			pd_q <= pd_d;
			mux_q <= mux_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs.
	// ------------------------------------------------------------
	assign reference_latch_out = ref_q;
	assign feedback_latch_out = fb_q;
	assign function_latch_out = func_q;
	assign output_active_out = active_q;
	assign power_down_out = pd_q;
	assign multiplexed_status_output = mux_q;

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	AST_SHIFT: assert property (@(posedge clock_in) disable iff (!rst_n)
		shift_pulse |=> shift_q[0] == $past(serial_data_in_level)) else $error("shift miss");
	AST_ORDER: assert property (@(posedge clock_in) disable iff (!rst_n)
		shift_pulse |=> shift_q[23:1] == $past(shift_q[22:0])) else $error("shift order");

	AST_REF: assert property (@(posedge clock_in) disable iff (!rst_n)
		load_pulse && shift_q[1:0] == SEL_REFERENCE |=> ref_q == $past(shift_q))
		else $error("ref load");
	AST_FB: assert property (@(posedge clock_in) disable iff (!rst_n)
		load_pulse && shift_q[1:0] == SEL_FEEDBACK |=> fb_q == $past(shift_q) && $stable(ref_q))
		else $error("fb load");
	AST_FUNC: assert property (@(posedge clock_in) disable iff (!rst_n)
		load_pulse && shift_q[1] |=> func_q == $past(shift_q)) else $error("func load");
	AST_HOLD: assert property (@(posedge clock_in) disable iff (!rst_n)
		!load_pulse |=> $stable(ref_q) && $stable(fb_q)) else $error("latch moved");

	AST_SETTLE: assert property (@(posedge clock_in) disable iff (!rst_n)
		!settled |=> $stable(done_q)) else $error("load before settle");
	AST_INIT: assert property (@(posedge clock_in) disable iff (!rst_n)
		load_pulse && shift_q[1:0] == SEL_INIT |=> done_q[2] && func_q == $past(shift_q))
		else $error("init load");
	AST_ACTIVE: assert property (@(posedge clock_in) disable iff (!rst_n)
		done_q != INIT_DONE_ALL |=> !active_q) else $error("early active");
	AST_ACTIVE_SET: assert property (@(posedge clock_in) disable iff (!rst_n)
		done_q == INIT_DONE_ALL |=> active_q) else $error("late active");

	AST_PD: assert property (@(posedge clock_in) disable iff (!rst_n)
		!pwr_level |=> pd_q) else $error("no power down");
	AST_PD_RUN: assert property (@(posedge clock_in) disable iff (!rst_n)
		pwr_level && !func_q[PD_BIT] |=> !pd_q) else $error("stuck power down");
	AST_PD_LOAD: assert property (@(posedge clock_in) disable iff (!rst_n)
		pd_q && load_pulse && shift_q[1:0] == SEL_REFERENCE |=> ref_q == $past(shift_q))
		else $error("load lost in power down");

	AST_MUX: assert property (@(posedge clock_in) disable iff (!rst_n)
		func_q[STATUS_LSB +: 2] != STATUS_LOCK_MODE |=> !mux_q) else $error("mux leak");
	AST_MUX_LOCK: assert property (@(posedge clock_in) disable iff (!rst_n)
		func_q[STATUS_LSB +: 2] == STATUS_LOCK_MODE |=> mux_q == $past(lock_level))
		else $error("lock not shown");
endmodule : pll_serial_latch_loader
`default_nettype wire

// [rtl/serial_loader_pkg.sv]
// Shared constants for the serial latch loader.
`default_nettype none
package serial_loader_pkg;
	localparam int WORD_BITS = 24;
	localparam logic [1:0] SEL_REFERENCE = 2'h0;
	localparam logic [1:0] SEL_FEEDBACK = 2'h1;
	localparam logic [1:0] SEL_FUNCTION = 2'h2;
	localparam logic [1:0] SEL_INIT = 2'h3;
	localparam logic [23:0] LATCH_RESET = 24'h000000;
	localparam logic [2:0] INIT_DONE_ALL = 3'h7;
	localparam logic [1:0] SYNC_RESET = 2'h0;
	localparam logic [2:0] FLAG_RESET = 3'h0;
	localparam logic [1:0] STATUS_LOCK_MODE = 2'h1;
	localparam int STATUS_LSB = 4;
	localparam int PD_BIT = 3;
endpackage : serial_loader_pkg
`default_nettype wire

// [rtl/sync_edge.sv]
// Two-flop synchroniser with rising-edge pulse.
`timescale 1ns/1ps
`default_nettype none
module sync_edge (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic async_in,
	output logic level_out,
	output logic rise_out
);
	logic first_q;
	logic second_q;
	logic third_q;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			first_q <= 1'b0;
			second_q <= 1'b0;
			third_q <= 1'b0;
		end else begin
			first_q <= async_in;
			second_q <= first_q;
			third_q <= second_q;
		end
	end
	assign level_out = second_q;
	assign rise_out = second_q & ~third_q;
endmodule : sync_edge
`default_nettype wire

// [sim/pll_serial_latch_loader_bench.sv]
// Self-checking bench for the serial latch loader.
`timescale 1ns/1ps
`default_nettype none
module pll_serial_latch_loader_bench;
	import serial_loader_pkg::*;
	logic clock_in, rst_n_in, sck, sdo, le, pwr, lock, active, pd, status;
	logic [23:0] ref_l, fb_l, fn_l;
	int mismatches = 0;
	int n_checks = 0;
	logic [24:0] rows [4] = '{25'h0123450, 25'h00abcd5, 25'h13c5a13, 25'h1a5a5aa};
	serial_host host (.clock_in(clock_in), .sck_out(sck), .sdo_out(sdo), .le_out(le));
	pll_serial_latch_loader uut (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.serial_clock_in(sck), .serial_data_in(sdo), .latch_load_strobe_in(le),
		.power_up_control_in(pwr), .lock_detect_in(lock), .reference_latch_out(ref_l),
		.feedback_latch_out(fb_l), .function_latch_out(fn_l), .output_active_out(active),
		.power_down_out(pd), .multiplexed_status_output(status));
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic load(input logic [23:0] word);
		host.send(word);
		repeat (6) @(negedge clock_in);
	endtask : load
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end
	initial begin
		rst_n_in = 1'b0;
		pwr = 1'b1;
		lock = 1'b0;
		repeat (6) @(negedge clock_in);
		check(24'(pd), 24'h1);
		check(24'(active), 24'h0);
		rst_n_in = 1'b1;
		repeat (6) @(negedge clock_in);
		foreach (rows[i]) begin
			load(rows[i][23:0]);
			case (rows[i][1:0])
				SEL_REFERENCE: check(ref_l, rows[i][23:0]);
				SEL_FEEDBACK: check(fb_l, rows[i][23:0]);
				default: check(fn_l, rows[i][23:0]);
			endcase
			check(24'(active), 24'(rows[i][24]));
		end
		check(24'(pd), 24'h1);
		load(24'h000012);
		check(24'(pd), 24'h0);
		check(24'(status), 24'h0);
		lock = 1'b1;
		repeat (6) @(negedge clock_in);
		check(24'(status), 24'h1);
		pwr = 1'b0;
		repeat (6) @(negedge clock_in);
		check(24'(pd), 24'h1);
		load(24'h55aa00);
		check(ref_l, 24'h55aa00);
		pwr = 1'b1;
		rst_n_in = 1'b0;
		repeat (6) @(negedge clock_in);
		check(ref_l, 24'h0);
		check(24'(active), 24'h0);
		check(24'(pd), 24'h1);
		rst_n_in = 1'b1;
		repeat (6) @(negedge clock_in);
		load(24'h000101);
		check(fb_l, 24'h000101);
		load(24'h000003);
		check(fn_l, 24'h000003);
		check(24'(active), 24'h0);
		load(24'h000100);
		check(ref_l, 24'h000100);
		check(24'(active), 24'h1);
		check(24'(pd), 24'h0);
		end_of_test();
	end
endmodule : pll_serial_latch_loader_bench
`default_nettype wire

// [sim/serial_host.sv]
// Host serial port model that shifts 24-bit words into the loader.
`timescale 1ns/1ps
`default_nettype none
module serial_host (
	input wire logic clock_in,
	output logic sck_out,
	output logic sdo_out,
	output logic le_out
);
	initial begin
		sck_out = 1'b0;
		sdo_out = 1'b0;
		le_out = 1'b1;
	end
	task automatic send(input logic [23:0] word);
		le_out = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdo_out = word[i];
			repeat (4) @(negedge clock_in);
			sck_out = 1'b1;
			repeat (4) @(negedge clock_in);
			sck_out = 1'b0;
		end
		sdo_out = ~word[0];
		repeat (4) @(negedge clock_in);
		le_out = 1'b1;
	endtask : send
endmodule : serial_host
`default_nettype wire
